/* File: hw/dcio_top.sv */
// one i/o card: select, input mux, output latches, serial terminal
`timescale 1ns/1ns
`default_nettype none
`include "dcio_regs.svh"
module dcio_top (
  input  wire logic            clk_i,
  input  wire logic            reset_n_i,
  input  wire logic [4:0]      module_addr_i,   // strap, card address
  input  wire dcio_pkg::dcio_cyc_s cyc_i,       // processor cycle
  input  wire logic [7:0]      output_data_lines_i,
  input  wire logic [7:0]      in_port2_i,      // external input port 2
  input  wire logic [7:0]      in_port3_i,      // external input port 3
  output logic      [7:0]      in_data_o,       // input data bus
  output logic                 card_en_o,       // card enable
  output logic      [7:0]      out_port10_o,    // external output 10
  output logic      [7:0]      out_port11_o,    // external output 11
  output logic      [7:0]      ser_ctl_o,       // port 9 control
  input  wire logic            ser_rx_i,        // terminal to card
  output logic                 ser_tx_o         // card to terminal
);
  import dcio_pkg::*;

  // synchronisers for pin inputs
  dcio_cyc_s c1_q, c_q;
  logic [4:0] m1_q, m_q;
  logic [15:0] p1_q, p_q;
  logic [7:0] d1_q, d_q;
  logic rx1_q, rx_q;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // strap copies reset to all ones and bus copies to zero, so the
      // stale reset values can never look like a card match
      c1_q <= '0; c_q <= '0; m1_q <= '1; m_q <= '1;
      p1_q <= 16'h0000; p_q <= 16'h0000; d1_q <= 8'h00; d_q <= 8'h00;
      rx1_q <= 1'b1; rx_q <= 1'b1;
    end else begin
      c1_q <= cyc_i; c_q <= c1_q;
      m1_q <= module_addr_i; m_q <= m1_q;
      p1_q <= {in_port3_i, in_port2_i}; p_q <= p1_q;
      d1_q <= output_data_lines_i; d_q <= d1_q;
      rx1_q <= ser_rx_i; rx_q <= rx1_q;
    end
  end

  // decode of port number from address lines
  function automatic logic [3:0] port_dec(input logic [1:0] n);
    port_dec = 4'h1 << n;
  endfunction

  // module and port select, direction from the strobes
  logic        card_en;
  logic [1:0]  port_num;
  logic [3:0]  in_en, out_en;
  always_comb begin
    card_en  = (c_q.addr[`DCIO_MOD_HI:`DCIO_MOD_LO] == m_q);
    port_num = c_q.addr[`DCIO_PSEL_HI:`DCIO_PSEL_LO];
    in_en    = (card_en && c_q.in_stb && c_q.phase)
               ? port_dec(port_num) : 4'h0;
    out_en   = (card_en && c_q.phase && c_q.out_stb)
               ? port_dec(port_num) : 4'h0;
  end
  assign card_en_o = card_en;

  // output latches, one per port
  logic [3:0][7:0] oport_q, oport_d;
  always_comb begin
    oport_d = oport_q;
    for (int i = 0; i < 4; i++) begin
      if (out_en[i]) begin
        oport_d[i] = d_q;
      end
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      oport_q <= '0;
    end else begin
      oport_q <= oport_d;
    end
  end
  assign ser_ctl_o    = oport_q[1];
  assign out_port10_o = oport_q[2];
  assign out_port11_o = oport_q[3];

  // two-entry transmit buffer fed by writes to port 8
  logic [1:0][7:0] tb_q, tb_d;
  logic [1:0]      tb_cnt_q, tb_cnt_d;
  logic            tb_in_valid, tb_in_ready, tb_out_valid, tb_out_ready;
  assign tb_in_valid  = out_en[0];
  assign tb_in_ready  = (tb_cnt_q != 2'h2);
  assign tb_out_valid = (tb_cnt_q != 2'h0);
  always_comb begin
    tb_d     = tb_q;
    tb_cnt_d = tb_cnt_q;
    if (tb_out_valid && tb_out_ready) begin
      tb_d[0]  = tb_q[1];
      tb_cnt_d = tb_cnt_d - 2'h1;
    end
    if (tb_in_valid && tb_in_ready) begin
      tb_d[tb_cnt_d[0]] = d_q;
      tb_cnt_d = tb_cnt_d + 2'h1;
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tb_q <= '0; tb_cnt_q <= 2'h0;
    end else begin
      tb_q <= tb_d; tb_cnt_q <= tb_cnt_d;
    end
  end

  // bit rate enable, one pulse per bit time
  logic [15:0] bd_q, bd_d;
  logic        bit_tick;
  always_comb begin
    bit_tick = (bd_q == `DCIO_BAUD_DIV);
    bd_d     = bit_tick ? 16'h0000 : bd_q + 16'h0001;
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) bd_q <= 16'h0000;
    else bd_q <= bd_d;
  end

  // transmitter: start, eight data, stop level held two bit times before the next start
  dcio_ser_e  tx_st_q, tx_st_d;
  logic [7:0] tx_sh_q, tx_sh_d;
  logic [3:0] tx_n_q, tx_n_d;
  logic       tx_q, tx_d;
  always_comb begin
    tx_st_d = tx_st_q; tx_sh_d = tx_sh_q; tx_n_d = tx_n_q; tx_d = tx_q;
    tb_out_ready = 1'b0;
    case (tx_st_q)
      DCIO_IDLE: begin
        tx_d = 1'b1;
        if (tb_out_valid && oport_q[1][`DCIO_CTL_TX_EN] && bit_tick) begin
          tb_out_ready = 1'b1;
          tx_sh_d = tb_q[0];
          tx_d = 1'b0;
          tx_st_d = DCIO_DATA;
          tx_n_d = 4'h0;
        end
      end
      DCIO_DATA: if (bit_tick) begin
        if (tx_n_q == `DCIO_SYM_DATA) begin
          tx_d = 1'b1; tx_st_d = DCIO_STOP;
        end else begin
          tx_d = tx_sh_q[0];
          tx_sh_d = {1'b0, tx_sh_q[7:1]};
          tx_n_d = tx_n_q + 4'h1;
        end
      end
      DCIO_STOP: if (bit_tick) tx_st_d = DCIO_IDLE;
      default: tx_st_d = DCIO_IDLE;
    endcase
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_st_q <= DCIO_IDLE; tx_sh_q <= 8'h00; tx_n_q <= 4'h0; tx_q <= 1'b1;
    end else begin
      tx_st_q <= tx_st_d; tx_sh_q <= tx_sh_d; tx_n_q <= tx_n_d; tx_q <= tx_d;
    end
  end
  assign ser_tx_o = tx_q;

  // receiver: samples mid bit after the start edge
  dcio_ser_e  rx_st_q, rx_st_d;
  logic [15:0] rc_q, rc_d;
  logic [3:0] rx_n_q, rx_n_d;
  logic [7:0] rx_sh_q, rx_sh_d, rx_buf_q, rx_buf_d;
  logic       rdy_q, rdy_d, ovr_q, ovr_d, fe_q, fe_d, ack;
  assign ack = out_en[1] && d_q[`DCIO_CTL_RX_ACK];
  always_comb begin
    rx_st_d = rx_st_q; rc_d = rc_q + 16'h0001; rx_n_d = rx_n_q;
    rx_sh_d = rx_sh_q; rx_buf_d = rx_buf_q;
    rdy_d = rdy_q & ~ack; ovr_d = ovr_q & ~ack; fe_d = fe_q & ~ack;
    case (rx_st_q)
      DCIO_IDLE: begin
        rc_d = 16'h0000;
        if (!rx_q) rx_st_d = DCIO_START;
      end
      DCIO_START: if (rc_q == (`DCIO_BAUD_DIV >> 1)) begin
        rc_d = 16'h0000; rx_n_d = 4'h0;
        rx_st_d = rx_q ? DCIO_IDLE : DCIO_DATA;
      end
      DCIO_DATA: if (rc_q == `DCIO_BAUD_DIV) begin
        rc_d = 16'h0000;
        rx_sh_d = {rx_q, rx_sh_q[7:1]};
        rx_n_d = rx_n_q + 4'h1;
        if (rx_n_q == `DCIO_SYM_DATA - 4'h1) rx_st_d = DCIO_STOP;
      end
      DCIO_STOP: if (rc_q == `DCIO_BAUD_DIV) begin
        rx_st_d = DCIO_IDLE;
        rx_buf_d = rx_sh_q;
        if (rdy_q && !ack) ovr_d = 1'b1;  // an ack in this cycle suppresses the overrun
        rdy_d = 1'b1;
        if (!rx_q) fe_d = 1'b1;
      end
      default: rx_st_d = DCIO_IDLE;
    endcase
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_st_q <= DCIO_IDLE; rc_q <= 16'h0000; rx_n_q <= 4'h0;
      rx_sh_q <= 8'h00; rx_buf_q <= 8'h00;
      rdy_q <= 1'b0; ovr_q <= 1'b0; fe_q <= 1'b0;
    end else begin
      rx_st_q <= rx_st_d; rc_q <= rc_d; rx_n_q <= rx_n_d;
      rx_sh_q <= rx_sh_d; rx_buf_q <= rx_buf_d;
      rdy_q <= rdy_d; ovr_q <= ovr_d; fe_q <= fe_d;
    end
  end

  // input multiplexer onto the registered input data bus
  logic [7:0] stat, in_d, in_q;
  always_comb begin
    stat = 8'h00;
    stat[`DCIO_ST_RX_READY]  = rdy_q;
    stat[`DCIO_ST_TX_BUSY]   = tb_out_valid || (tx_st_q != DCIO_IDLE);
    stat[`DCIO_ST_OVERRUN]   = ovr_q;
    stat[`DCIO_ST_FRAME_ERR] = fe_q;
    case (1'b1)
      in_en[0]: in_d = rx_buf_q;
      in_en[1]: in_d = stat;
      in_en[2]: in_d = p_q[7:0];
      in_en[3]: in_d = p_q[15:8];
      default:  in_d = 8'h00;
    endcase
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) in_q <= 8'h00;
    else in_q <= in_d;
  end
  assign in_data_o = in_q;

  // checks
  out_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    out_en[2] == 1'b0 |=> $stable(out_port10_o))
    else $error("output port changed without write");
  // the bus only carries data after a fully qualified input cycle
  in_gate_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (in_data_o != 8'h00) |->
    $past(card_en && c_q.in_stb && c_q.phase))
    else $error("input bus driven without qualifiers");
  // a latch only moves after a fully qualified output cycle
  out_gate_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $changed(oport_q) |->
    $past(card_en && c_q.out_stb && c_q.phase))
    else $error("output latch changed without qualifiers");
  out_cap_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    out_en[3] |=> out_port11_o == $past(d_q))
    else $error("output data not captured");
  in_drive_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    in_en[2] |=> in_data_o == $past(p_q[7:0]))
    else $error("input port not driven");
  one_hot_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $onehot0(in_en) && $onehot0(out_en))
    else $error("port enables not one hot");
  // a latch move or a driven input bus needs the card's own module address
  card_sel_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ($changed(oport_q) || (in_data_o != 8'h00)) |->
    $past(c_q.addr[`DCIO_MOD_HI:`DCIO_MOD_LO] == m_q))
    else $error("card acted on foreign address");
  sequence tx_start_s;
    tx_st_q == DCIO_IDLE ##1 tx_st_q == DCIO_DATA;
  endsequence
  tx_frame_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    tx_start_s |-> ser_tx_o == 1'b0)
    else $error("start bit missing");
endmodule
`default_nettype wire

/* File: hw/dcio_regs.svh */
// constants and contract list for the dual card i/o port block
`ifndef DCIO_REGS_SVH
`define DCIO_REGS_SVH
`define DCIO_PSEL_LO      9
`define DCIO_PSEL_HI      10
`define DCIO_MOD_LO       11
`define DCIO_MOD_HI       15
`define DCIO_PORT_DATA    2'h0
`define DCIO_PORT_STAT    2'h1
`define DCIO_BAUD_DIV     16'h0d9
`define DCIO_FRAME_BITS   4'h9
`define DCIO_SYM_DATA     4'h8
`define DCIO_ST_RX_READY  0
`define DCIO_ST_TX_BUSY   1
`define DCIO_ST_OVERRUN   2
`define DCIO_ST_FRAME_ERR 3
`define DCIO_CTL_RX_ACK   0
`define DCIO_CTL_TX_EN    1
`endif

/* File: hw/dcio_pkg.sv */
// types shared by the dual card i/o port block
package dcio_pkg;
  // processor side address and strobes
  typedef struct packed {
    logic [15:0] addr;    // multiplexed address bus
    logic        in_stb;  // input strobe
    logic        out_stb; // output strobe
    logic        phase;   // cycle phase qualifier
  } dcio_cyc_s;
  // serial engine states
  typedef enum logic [3:0] {
    DCIO_IDLE  = 4'b0001,
    DCIO_START = 4'b0010,
    DCIO_DATA  = 4'b0100,
    DCIO_STOP  = 4'b1000
  } dcio_ser_e;
endpackage

/* File: test/dcio_cpu_model.sv */
// processor and terminal stand-in that drives the card's pins
`timescale 1ns/1ns
`default_nettype none
module dcio_cpu_model (
  input  wire logic           clk_i,
  input  wire logic [7:0]     in_data_i,
  output var dcio_pkg::dcio_cyc_s cyc_o,
  output logic      [7:0]     wdata_o,
  output logic                rx_o
);
  import dcio_pkg::*;
  localparam int BIT_CLKS = 218; // clocks per serial bit
  // idle bus, idle high serial line
  initial begin
    cyc_o = '0;
    wdata_o = 8'h00;
    rx_o = 1'b1;
  end
  // output cycle: address, data and strobe held for one clock
  task automatic io_wr(input logic [4:0] card, input logic [1:0] port,
                       input logic [7:0] data);
    @(negedge clk_i);
    cyc_o.addr = {card, port, 9'h000};
    wdata_o = data;
    cyc_o.phase = 1'b1;
    cyc_o.out_stb = 1'b1;
    @(negedge clk_i);
    cyc_o = '0;
    wdata_o = ~data; // released data must not show the last value
    repeat (4) @(negedge clk_i);
  endtask
  // input cycle: strobe held until the answer has settled
  task automatic io_rd(input logic [4:0] card, input logic [1:0] port,
                       input logic phase, output logic [7:0] data);
    @(negedge clk_i);
    cyc_o.addr = {card, port, 9'h000};
    cyc_o.phase = phase;
    cyc_o.in_stb = 1'b1;
    repeat (4) @(negedge clk_i);
    data = in_data_i;
    cyc_o = '0;
    repeat (3) @(negedge clk_i);
  endtask
  // terminal sends one character, start bit then lsb first
  task automatic ser_send(input logic [7:0] ch);
    @(negedge clk_i);
    rx_o = 1'b0;
    repeat (BIT_CLKS) @(negedge clk_i);
    for (int i = 0; i < 8; i++) begin
      rx_o = ch[i];
      repeat (BIT_CLKS) @(negedge clk_i);
    end
    rx_o = 1'b1;
    repeat (2 * BIT_CLKS) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// self-checking bench for one i/o card
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import dcio_pkg::*;
  localparam logic [4:0] CARD  = 5'h05; // strap of the card under test
  localparam logic [4:0] OTHER = 5'h0a; // address of an absent card
  localparam int         BIT_CLKS = 218;
  logic       clk_i, reset_n_i, ser_tx_o, card_en_o, ser_rx;
  logic [7:0] in_data_o, out_port10_o, out_port11_o, ser_ctl_o;
  logic [7:0] wdata, in2, in3, rd;
  logic [4:0] strap; // module address strap, changed by one scenario
  dcio_cyc_s  cyc;
  int         miscompares = 0;
  int         checks = 0;
  int         cycles = 0;
  dcio_top u_dcio_top (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .module_addr_i(strap), .cyc_i(cyc), .output_data_lines_i(wdata),
    .in_port2_i(in2), .in_port3_i(in3), .in_data_o(in_data_o),
    .card_en_o(card_en_o), .out_port10_o(out_port10_o),
    .out_port11_o(out_port11_o), .ser_ctl_o(ser_ctl_o),
    .ser_rx_i(ser_rx), .ser_tx_o(ser_tx_o));
  dcio_cpu_model u_dcio_cpu_model (.clk_i(clk_i), .in_data_i(in_data_o),
    .cyc_o(cyc), .wdata_o(wdata), .rx_o(ser_rx));
  // clock, 8 ns period
  initial begin
    clk_i = 1'b1;
    forever #4 clk_i = ~clk_i;
  end
  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end
  // compare and count
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // values straight after reset
  task automatic t_reset();
    chk("in_data", 8'h00, in_data_o);
    chk("out10", 8'h00, out_port10_o);
    chk("card_en", 8'h00, {7'h00, card_en_o});
    chk("tx idle", 8'h01, {7'h00, ser_tx_o});
  endtask
  // latches take data, keep it, ignore another card
  task automatic t_out_latch();
    u_dcio_cpu_model.io_wr(CARD, 2'h2, 8'h3c);
    u_dcio_cpu_model.io_wr(CARD, 2'h3, 8'hc3);
    chk("out10", 8'h3c, out_port10_o);
    chk("out11", 8'hc3, out_port11_o);
    u_dcio_cpu_model.io_wr(OTHER, 2'h2, 8'h55);
    u_dcio_cpu_model.io_wr(CARD, 2'h3, 8'h81);
    chk("out10 kept", 8'h3c, out_port10_o);
    chk("out11 new", 8'h81, out_port11_o);
    strap = OTHER;
    u_dcio_cpu_model.io_wr(OTHER, 2'h2, 8'h66);
    chk("out10 moved", 8'h66, out_port10_o);
    u_dcio_cpu_model.io_wr(CARD, 2'h2, 8'h99);
    chk("out10 ignored", 8'h66, out_port10_o);
    strap = CARD;
  endtask
  // input mux, wrong card and missing phase give nothing
  task automatic t_in_mux();
    in2 = 8'h5a;
    in3 = 8'ha5;
    fork
      u_dcio_cpu_model.io_rd(CARD, 2'h2, 1'b1, rd);
      begin
        repeat (3) @(negedge clk_i);
        chk("card_en", 8'h01, {7'h00, card_en_o});
      end
    join
    chk("in2", 8'h5a, rd);
    u_dcio_cpu_model.io_rd(CARD, 2'h3, 1'b1, rd);
    chk("in3", 8'ha5, rd);
    fork
      u_dcio_cpu_model.io_rd(OTHER, 2'h2, 1'b1, rd);
      begin
        repeat (3) @(negedge clk_i);
        chk("card_en other", 8'h00, {7'h00, card_en_o});
      end
    join
    chk("other card", 8'h00, rd);
    u_dcio_cpu_model.io_rd(CARD, 2'h2, 1'b0, rd);
    chk("no phase", 8'h00, rd);
  endtask
  // transmit one character and capture the frame
  task automatic t_tx();
    logic [9:0] frame;
    logic [9:0] exp;
    exp = {1'b1, 8'ha6, 1'b0};
    u_dcio_cpu_model.io_wr(CARD, 2'h1, 8'h02);
    chk("ser_ctl", 8'h02, ser_ctl_o);
    fork
      begin
        for (int w = 0; w < 1000 && ser_tx_o === 1'b1; w++)
          @(negedge clk_i);
        repeat (BIT_CLKS / 2) @(negedge clk_i);
        for (int i = 0; i < 10; i++) begin
          frame[i] = ser_tx_o;
          repeat (BIT_CLKS) @(negedge clk_i);
        end
      end
      begin
        u_dcio_cpu_model.io_wr(CARD, 2'h0, 8'ha6);
        u_dcio_cpu_model.io_rd(CARD, 2'h1, 1'b1, rd);
        chk("tx busy", 8'h02, rd & 8'h02);
      end
    join
    chk("frame lo", exp[7:0], frame[7:0]);
    chk("frame hi", {6'h00, exp[9:8]}, {6'h00, frame[9:8]});
  endtask
  // receive one character, read it, clear status
  task automatic t_rx();
    u_dcio_cpu_model.ser_send(8'h3b);
    u_dcio_cpu_model.io_rd(CARD, 2'h1, 1'b1, rd);
    chk("rx ready", 8'h01, rd & 8'h01);
    u_dcio_cpu_model.io_rd(CARD, 2'h0, 1'b1, rd);
    chk("rx data", 8'h3b, rd);
    u_dcio_cpu_model.io_wr(CARD, 2'h1, 8'h03);
    chk("ser_ctl ack", 8'h03, ser_ctl_o);
    u_dcio_cpu_model.io_rd(CARD, 2'h1, 1'b1, rd);
    chk("rx cleared", 8'h00, rd & 8'h01);
  endtask
  // main sequence
  initial begin
    reset_n_i = 1'b0;
    strap = CARD;
    in2 = 8'h00;
    in3 = 8'h00;
    repeat (20) @(negedge clk_i);
    reset_n_i = 1'b1;
    t_reset();
    t_out_latch();
    t_in_mux();
    t_tx();
    t_rx();
    results();
  end
endmodule
`default_nettype wire
